// ==== src/sssp_defs.svh ====
`ifndef SSSP_DEFS_SVH
`define SSSP_DEFS_SVH

// control characters
`define SSSP_SOH        8'h01
`define SSSP_STX        8'h02
`define SSSP_ETX        8'h03
`define SSSP_EOT        8'h04
`define SSSP_STAR       8'h2a

// status codes, upper case while no alarm is active
`define SSSP_ST_GOOD    8'h41
`define SSSP_ST_PARITY  8'h42
`define SSSP_ST_CSUM    8'h43
`define SSSP_ST_CHAR    8'h44
`define SSSP_ST_CMD     8'h45
`define SSSP_ST_DNUM    8'h46
`define SSSP_ALARM_BIT  8'h20

// station and group encodings
`define SSSP_MAX_STN    5'h1f
`define SSSP_GRP_FIRST  8'h61
`define SSSP_GRP_LAST   8'h66

// timing: clock 20 MHz, baud chosen at 500000, forty clocks a bit
`define SSSP_CLK_HZ     20000000
`define SSSP_BAUD       500000
`define SSSP_BIT_CYC    (`SSSP_CLK_HZ / `SSSP_BAUD)
`define SSSP_HALF_CYC   (`SSSP_BIT_CYC / 2)
`define SSSP_FRAME_BITS 4'd11

// message field lengths
`define SSSP_CMD_LEN    3'd2
`define SSSP_DNO_LEN    3'd2
`define SSSP_MAX_DATA   5'd16

`endif

// ==== src/sssp_pkg.sv ====
package sssp_pkg;

    // one decoded command handed to the servo core
    typedef struct packed {
        logic [7:0]       station;
        logic [15:0]      command;
        logic [15:0]      data_no;
        logic [4:0]       data_len;
        logic [16*8-1:0]  data;
        logic             broadcast;
    } sssp_cmd_t;

    // answer from the servo core
    typedef struct packed {
        logic             valid;
        logic             cmd_bad;
        logic             dno_bad;
        logic [4:0]       data_len;
        logic [16*8-1:0]  data;
    } sssp_rsp_t;

    // configuration from stored parameters
    typedef struct packed {
        logic             use_p2p;
        logic [4:0]       station;
        logic [7:0]       group;
    } sssp_cfg_t;

endpackage

// ==== src/sssp_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sssp_defs.svh"

module sssp_slave (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    input  wire sssp_pkg::sssp_cfg_t cfg_i,
    input  wire logic              alarm_i,
    input  wire logic              rx485_i,
    input  wire logic              rx232_i,
    output logic                   tx485_o,
    output logic                   tx485_oe_o,
    output logic                   tx232_o,
    output sssp_pkg::sssp_cmd_t    cmd_o,
    output logic                   cmd_valid_o,
    input  wire sssp_pkg::sssp_rsp_t rsp_i
);

    typedef enum logic [3:0] {
        SSSP_IDLE, SSSP_STN, SSSP_CMD, SSSP_WAIT_STX, SSSP_DNO, SSSP_DATA,
        SSSP_CS_HI, SSSP_CS_LO, SSSP_EXEC, SSSP_WAIT_RSP, SSSP_REPLY
    } sssp_state_t;

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_val = 4'(c - 8'h30);
        end else if (c >= 8'h41 && c <= 8'h46) begin
            hex_val = 4'(c - 8'h37);
        end else begin
            hex_val = 4'h0;
        end
    endfunction

    function automatic logic [7:0] hex_chr(input logic [3:0] v);
        hex_chr = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
    endfunction

    function automatic logic is_hex(input logic [7:0] c);
        is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction

    // station number to ascii, 0-9 then A-V
    function automatic logic [7:0] stn_chr(input logic [4:0] s);
        stn_chr = (s < 5'd10) ? (8'h30 + {3'h0, s}) : (8'h37 + {3'h0, s});
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and line select

    logic [1:0] sync485;
    logic [1:0] sync232;
    logic       rx_line;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync485 <= 2'h3;
            sync232 <= 2'h3;
        end else if (ce_i) begin
            sync485 <= {sync485[0], rx485_i};
            sync232 <= {sync232[0], rx232_i};
        end
    end

    assign rx_line = cfg_i.use_p2p ? sync232[1] : sync485[1];

    ////////////////////////////////////////////////////////////////////////////////
    // receiver

    logic [15:0] rx_cnt, next_rx_cnt;
    logic [3:0]  rx_bit, next_rx_bit;
    logic [8:0]  rx_sh, next_rx_sh;
    logic        rx_busy, next_rx_busy;
    logic        rx_stb, next_rx_stb;
    logic        rx_perr, next_rx_perr;
    logic [7:0]  rx_byte, next_rx_byte;

    always_comb begin
        next_rx_cnt  = rx_cnt;
        next_rx_bit  = rx_bit;
        next_rx_sh   = rx_sh;
        next_rx_busy = rx_busy;
        next_rx_stb  = 1'b0;
        next_rx_perr = rx_perr;
        next_rx_byte = rx_byte;
        if (!rx_busy) begin
            if (!rx_line) begin
                next_rx_busy = 1'b1;
                next_rx_cnt  = 16'(`SSSP_HALF_CYC);
                next_rx_bit  = 4'h0;
            end
        end else if (rx_cnt != 16'h0) begin
            next_rx_cnt = rx_cnt - 16'h1;
        end else begin
            next_rx_cnt = 16'(`SSSP_BIT_CYC - 1);
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == 4'h0) begin
                // false start glitch
                if (rx_line) begin
                    next_rx_busy = 1'b0;
                end
            end else if (rx_bit < `SSSP_FRAME_BITS - 4'h1) begin
                next_rx_sh = {rx_line, rx_sh[8:1]};
            end else begin
                next_rx_busy = 1'b0;
                next_rx_stb  = 1'b1;
                next_rx_byte = rx_sh[7:0];
                next_rx_perr = (^rx_sh) | ~rx_line;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_cnt  <= 16'h0;
            rx_bit  <= 4'h0;
            rx_sh   <= 9'h0;
            rx_busy <= 1'b0;
            rx_stb  <= 1'b0;
            rx_perr <= 1'b0;
            rx_byte <= 8'h0;
        end else if (ce_i) begin
            rx_cnt  <= next_rx_cnt;
            rx_bit  <= next_rx_bit;
            rx_sh   <= next_rx_sh;
            rx_busy <= next_rx_busy;
            rx_stb  <= next_rx_stb;
            rx_perr <= next_rx_perr;
            rx_byte <= next_rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // message parser and reply builder

    sssp_state_t         st, next_st;
    sssp_pkg::sssp_cmd_t cmd, next_cmd;
    logic [2:0]          idx, next_idx;
    logic [7:0]          sum, next_sum;
    logic [7:0]          cs_rx, next_cs_rx;
    logic                perr, next_perr;
    logic                cerr, next_cerr;
    logic                mine, next_mine;
    logic                cv, next_cv;
    logic [7:0]          reply [0:23];
    logic [7:0]          next_reply [0:23];
    logic [4:0]          rlen, next_rlen;
    logic [4:0]          rpos, next_rpos;
    logic                tx_go;
    logic                tx_done;
    logic                tx_busy, next_tx_busy;
    logic [7:0]          status;
    logic [7:0]          rsum;
    logic                addressed;

    assign addressed = (rx_byte == `SSSP_STAR) || (rx_byte == stn_chr(cfg_i.station)) ||
                       (rx_byte == cfg_i.group && rx_byte >= `SSSP_GRP_FIRST &&
                        rx_byte <= `SSSP_GRP_LAST);

    always_comb begin
        next_st    = st;
        next_cmd   = cmd;
        next_idx   = idx;
        next_sum   = sum;
        next_cs_rx = cs_rx;
        next_perr  = perr;
        next_cerr  = cerr;
        next_mine  = mine;
        next_cv    = 1'b0;
        next_rlen  = rlen;
        next_rpos  = rpos;
        next_reply = reply;
        tx_go      = 1'b0;
        status     = `SSSP_ST_GOOD;
        rsum       = 8'h0;
        if (rx_stb && rx_byte == `SSSP_EOT && st != SSSP_REPLY) begin
            next_st = SSSP_IDLE;
        end else if (rx_stb && rx_byte == `SSSP_SOH && st != SSSP_REPLY) begin
            next_st   = SSSP_STN;
            next_sum  = 8'h0;
            next_perr = rx_perr;
            next_cerr = 1'b0;
            next_cmd  = '0;
        end else begin
            unique case (st)
                SSSP_IDLE, SSSP_EXEC, SSSP_WAIT_RSP, SSSP_REPLY: ;
                default: if (rx_stb) begin
                    next_perr = perr | rx_perr;
                    if (st != SSSP_CS_HI && st != SSSP_CS_LO) begin
                        next_sum = sum + rx_byte;
                    end
                end
            endcase
            unique case (st)
                SSSP_IDLE: ;
                SSSP_STN: if (rx_stb) begin
                    next_cmd.station   = rx_byte;
                    next_cmd.broadcast = (rx_byte == `SSSP_STAR);
                    next_mine          = addressed;
                    next_idx           = 3'h0;
                    next_st            = SSSP_CMD;
                end
                SSSP_CMD: if (rx_stb) begin
                    next_cerr   = cerr | ~is_hex(rx_byte);
                    next_cmd.command = {cmd.command[7:0], rx_byte};
                    next_idx    = idx + 3'h1;
                    if (idx == `SSSP_CMD_LEN - 3'h1) begin
                        next_st = SSSP_WAIT_STX;
                    end
                end
                SSSP_WAIT_STX: if (rx_stb) begin
                    next_idx = 3'h0;
                    next_cerr = cerr | (rx_byte != `SSSP_STX);
                    next_st  = SSSP_DNO;
                end
                SSSP_DNO: if (rx_stb) begin
                    next_cmd.data_no = {cmd.data_no[7:0], rx_byte};
                    next_idx = idx + 3'h1;
                    if (idx == `SSSP_DNO_LEN - 3'h1) begin
                        next_st = SSSP_DATA;
                    end
                end
                SSSP_DATA: if (rx_stb) begin
                    if (rx_byte == `SSSP_ETX) begin
                        next_st = SSSP_CS_HI;
                        next_cerr = cerr | (cmd.data_len[1:0] != 2'h0);
                    end else if (cmd.data_len == `SSSP_MAX_DATA) begin
                        next_cerr = 1'b1;
                    end else begin
                        next_cmd.data     = {cmd.data[15*8-1:0], rx_byte};
                        next_cmd.data_len = cmd.data_len + 5'h1;
                    end
                end
                SSSP_CS_HI: if (rx_stb) begin
                    next_cs_rx[7:4] = hex_val(rx_byte);
                    next_cerr = cerr | ~is_hex(rx_byte);
                    next_st   = SSSP_CS_LO;
                end
                SSSP_CS_LO: if (rx_stb) begin
                    next_cs_rx[3:0] = hex_val(rx_byte);
                    next_cerr = cerr | ~is_hex(rx_byte);
                    next_st   = mine ? SSSP_EXEC : SSSP_IDLE;
                end
                SSSP_EXEC: begin
                    if (perr || cerr || cs_rx != sum) begin
                        next_st = SSSP_REPLY;
                        next_rlen = 5'h0;
                    end else begin
                        next_cv = 1'b1;
                        next_st = SSSP_WAIT_RSP;
                    end
                end
                SSSP_WAIT_RSP: if (rsp_i.valid) begin
                    next_st   = SSSP_REPLY;
                    next_rlen = rsp_i.data_len;
                    for (int i = 0; i < 16; i++) begin
                        next_reply[3 + i] = rsp_i.data[(15 - i) * 8 +: 8];
                    end
                end
                SSSP_REPLY: ;
            endcase
        end
        if (st == SSSP_REPLY && rpos == 5'h0 && !tx_busy) begin
            if (perr) begin
                status = `SSSP_ST_PARITY;
            end else if (cs_rx != sum) begin
                status = `SSSP_ST_CSUM;
            end else if (cerr) begin
                status = `SSSP_ST_CHAR;
            end else if (rsp_i.cmd_bad) begin
                status = `SSSP_ST_CMD;
            end else if (rsp_i.dno_bad) begin
                status = `SSSP_ST_DNUM;
            end
            if (alarm_i) begin
                status = status | `SSSP_ALARM_BIT;
            end
            next_reply[0] = `SSSP_STX;
            next_reply[1] = stn_chr(cfg_i.station);
            next_reply[2] = status;
            next_reply[3 + 32'(next_rlen)] = `SSSP_ETX;
            rsum = stn_chr(cfg_i.station) + status + `SSSP_ETX;
            for (int i = 0; i < 16; i++) begin
                if (5'(i) < next_rlen) begin
                    rsum = rsum + next_reply[3 + i];
                end
            end
            next_reply[4 + 32'(next_rlen)] = hex_chr(rsum[7:4]);
            next_reply[5 + 32'(next_rlen)] = hex_chr(rsum[3:0]);
            if (cmd.broadcast && cfg_i.station != 5'h0) begin
                next_st = SSSP_IDLE;
            end else begin
                tx_go     = 1'b1;
                next_rpos = 5'h1;
            end
        end else if (st == SSSP_REPLY && tx_done) begin
            if (rpos == rlen + 5'd6) begin
                next_st   = SSSP_IDLE;
                next_rpos = 5'h0;
            end else begin
                tx_go     = 1'b1;
                next_rpos = rpos + 5'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st    <= SSSP_IDLE;
            cmd   <= '0;
            idx   <= 3'h0;
            sum   <= 8'h0;
            cs_rx <= 8'h0;
            perr  <= 1'b0;
            cerr  <= 1'b0;
            mine  <= 1'b0;
            cv    <= 1'b0;
            rlen  <= 5'h0;
            rpos  <= 5'h0;
            for (int i = 0; i < 24; i++) begin
                reply[i] <= 8'h0;
            end
        end else if (ce_i) begin
            st    <= next_st;
            cmd   <= next_cmd;
            idx   <= next_idx;
            sum   <= next_sum;
            cs_rx <= next_cs_rx;
            perr  <= next_perr;
            cerr  <= next_cerr;
            mine  <= next_mine;
            cv    <= next_cv;
            rlen  <= next_rlen;
            rpos  <= next_rpos;
            reply <= next_reply;
        end
    end

    assign cmd_o       = cmd;
    assign cmd_valid_o = cv;

    ////////////////////////////////////////////////////////////////////////////////
    // transmitter

    logic [15:0] tx_cnt, next_tx_cnt;
    logic [3:0]  tx_bit, next_tx_bit;
    logic [10:0] tx_sh, next_tx_sh;
    logic        tx_line;
    logic [7:0]  tx_byte;

    // the first byte leaves before the reply table is written, so start-of-text comes direct
    assign tx_byte = (next_rpos == 5'h1) ? `SSSP_STX : reply[next_rpos - 5'h1];

    always_comb begin
        next_tx_cnt  = tx_cnt;
        next_tx_bit  = tx_bit;
        next_tx_sh   = tx_sh;
        next_tx_busy = tx_busy;
        // done comes from state alone, so chaining the next byte on it forms no loop
        tx_done      = tx_busy && (tx_cnt == 16'h0) && (tx_bit == `SSSP_FRAME_BITS - 4'h1);
        if (tx_go) begin
            next_tx_sh   = {1'b1, ^tx_byte, tx_byte, 1'b0};
            next_tx_busy = 1'b1;
            next_tx_bit  = 4'h0;
            next_tx_cnt  = 16'(`SSSP_BIT_CYC - 1);
        end else if (tx_busy) begin
            if (tx_cnt != 16'h0) begin
                next_tx_cnt = tx_cnt - 16'h1;
            end else if (tx_done) begin
                next_tx_busy = 1'b0;
            end else begin
                next_tx_cnt = 16'(`SSSP_BIT_CYC - 1);
                next_tx_bit = tx_bit + 4'h1;
                next_tx_sh  = {1'b1, tx_sh[10:1]};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_cnt  <= 16'h0;
            tx_bit  <= 4'h0;
            tx_sh   <= 11'h7ff;
            tx_busy <= 1'b0;
        end else if (ce_i) begin
            tx_cnt  <= next_tx_cnt;
            tx_bit  <= next_tx_bit;
            tx_sh   <= next_tx_sh;
            tx_busy <= next_tx_busy;
        end
    end

    assign tx_line = tx_busy ? tx_sh[0] : 1'b1;

    assign tx485_o    = tx_line;
    assign tx485_oe_o = tx_busy & ~cfg_i.use_p2p;
    assign tx232_o    = cfg_i.use_p2p ? tx_line : 1'b1;

endmodule // sssp_slave

`default_nettype wire

// ==== verification/sssp_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sssp_defs.svh"
module sssp_master_model (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    localparam int BIT = `SSSP_BIT_CYC;
    initial line_o = 1'b1;

    // start, lsb first, even parity, stop
    task automatic send_byte(input logic [7:0] b, input logic last);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_o = f[i];
            repeat ((i == 10 && last) ? BIT / 2 : BIT) @(negedge clk_i);
        end
    endtask

    // a silent slave is given up on
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        logic [10:0] f;
        int          n;
        n = 0;
        while (line_i !== 1'b0 && n < 16 * BIT) begin
            @(negedge clk_i);
            n++;
        end
        repeat (BIT / 2) @(negedge clk_i);
        for (int i = 0; i < 11; i++) begin
            f[i] = line_i;
            if (i < 10) repeat (BIT) @(negedge clk_i);
        end
        b = f[8:1];
        ok = (n < 16 * BIT) && f[0] === 1'b0 && f[10] === 1'b1 && f[9] === ^f[8:1];
    endtask
endmodule // sssp_master_model
`default_nettype wire

// ==== verification/sssp_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sssp_monitor (
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic                ce_i,
    input wire sssp_pkg::sssp_cfg_t cfg_i,
    input wire logic                alarm_i,
    input wire logic                rx485_i,
    input wire logic                rx232_i,
    input wire logic                tx485_o,
    input wire logic                tx485_oe_o,
    input wire logic                tx232_o,
    input wire sssp_pkg::sssp_cmd_t cmd_o,
    input wire logic                cmd_valid_o,
    input wire sssp_pkg::sssp_rsp_t rsp_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [16:0] quiet;
    logic [16:0] next_quiet;

    function automatic logic [7:0] stn_chr(input logic [4:0] s);
        return (s < 5'd10) ? 8'h30 + {3'h0, s} : 8'h37 + {3'h0, s};
    endfunction

    // cycles since the master last pulled its line low
    always_comb begin
        next_quiet = (quiet == 17'h1ffff) ? quiet : quiet + 17'h1;
        if (!rx485_i || !rx232_i) begin
            next_quiet = 17'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        quiet <= rst_n_i ? next_quiet : 17'h0;
    end

    ////////////////////////////////////////////////////////////////////
    a_reset_idle: assert property (disable iff (1'b0) (!rst_n_i && ce_i) |=>
        (tx485_o && tx232_o && !tx485_oe_o && !cmd_valid_o && cmd_o == '0))
        else $error("outputs not idle after reset");
    a_p2p_no_oe: assert property (cfg_i.use_p2p |-> !tx485_oe_o)
        else $error("multidrop driven while point-to-point selected");
    a_p2p_idle: assert property (!cfg_i.use_p2p |-> tx232_o)
        else $error("point-to-point line active while multidrop selected");
    a_oe_stop: assert property ($fell(tx485_oe_o) |-> $past(tx485_o))
        else $error("multidrop released outside a stop bit");
    a_reply_asked: assert property ($rose(tx485_oe_o) |-> quiet < 17'd30000)
        else $error("reply with no recent message");
    a_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command strobe longer than one cycle");
    a_cmd_addr: assert property (cmd_valid_o |-> (cmd_o.station == 8'h2a
        || cmd_o.station == stn_chr(cfg_i.station) || cmd_o.station == cfg_i.group))
        else $error("command for another station executed");
    a_bcast_flag: assert property (cmd_valid_o |-> cmd_o.broadcast == (cmd_o.station == 8'h2a))
        else $error("wildcard flag wrong");
    a_reply_start: assert property (rsp_i.valid && (!cmd_o.broadcast || cfg_i.station == 5'h0)
        |-> ##[1:2] (cfg_i.use_p2p ? !tx232_o : tx485_oe_o))
        else $error("reply did not start after core answer");
    a_bcast_quiet: assert property (rsp_i.valid && cmd_o.broadcast && cfg_i.station != 5'h0
        |=> (!tx485_oe_o && tx232_o)[*8])
        else $error("wildcard answered by nonzero station");

    c_cmd: cover property (cmd_valid_o);
    c_bcast: cover property (cmd_valid_o && cmd_o.broadcast);
    c_md_reply: cover property ($rose(tx485_oe_o));
    c_p2p_reply: cover property (cfg_i.use_p2p && $fell(tx232_o));
endmodule // sssp_monitor

bind sssp_slave sssp_monitor i_sssp_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg_i(cfg_i), .alarm_i(alarm_i),
    .rx485_i(rx485_i), .rx232_i(rx232_i), .tx485_o(tx485_o), .tx485_oe_o(tx485_oe_o),
    .tx232_o(tx232_o), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .rsp_i(rsp_i)
);
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sssp_defs.svh"
module tb_top;
    logic                clk_i;
    logic                rst_n_i;
    logic                ce_i;
    logic                alarm_i;
    sssp_pkg::sssp_cfg_t cfg_i;
    sssp_pkg::sssp_rsp_t rsp_i;
    sssp_pkg::sssp_cmd_t cmd_o;
    logic                cmd_valid_o;
    logic                tx485_o;
    logic                tx485_oe_o;
    logic                tx232_o;
    logic                m_line;
    logic                rl_q;
    int                  error_cnt, check_count, vcnt, edge_cnt;
    // multidrop bus has a failsafe pull-up
    wire logic           bus = tx485_oe_o ? tx485_o : 1'b1;
    wire logic           reply_line = cfg_i.use_p2p ? tx232_o : bus;

    sssp_slave i_sssp_slave (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg_i(cfg_i), .alarm_i(alarm_i),
        .rx485_i(cfg_i.use_p2p ? 1'b1 : m_line), .rx232_i(cfg_i.use_p2p ? m_line : 1'b1),
        .tx485_o(tx485_o), .tx485_oe_o(tx485_oe_o), .tx232_o(tx232_o),
        .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .rsp_i(rsp_i));
    sssp_master_model i_sssp_master_model (.clk_i(clk_i), .line_i(reply_line), .line_o(m_line));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        rl_q <= reply_line;
        if (rl_q === 1'b1 && reply_line === 1'b0) edge_cnt++;
        if (cmd_valid_o === 1'b1) vcnt++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // every message names a station; sum skips the leading start code
    task automatic send_msg(input logic [7:0] stn, input logic bad);
        logic [7:0] q[$];
        logic [7:0] s;
        q = '{stn, 8'h30, 8'h31, `SSSP_STX, 8'h30, 8'h32, `SSSP_ETX};
        s = 8'h00;
        foreach (q[i]) s += q[i];
        if (bad) s ^= 8'h01;
        i_sssp_master_model.send_byte(`SSSP_SOH, 1'b0);
        foreach (q[i]) i_sssp_master_model.send_byte(q[i], 1'b0);
        i_sssp_master_model.send_byte(hx(s[7:4]), 1'b0);
        i_sssp_master_model.send_byte(hx(s[3:0]), 1'b1);
        repeat (8) @(negedge clk_i);
    endtask

    task automatic expect_reply(input logic [7:0] stn, input logic [7:0] st, input logic dat);
        logic [7:0] q[$];
        logic [7:0] s, b;
        logic       ok;
        q = '{stn, st};
        if (dat) q = '{stn, st, 8'h31, 8'h32, 8'h33, 8'h34};
        q.push_back(`SSSP_ETX);
        s = 8'h00;
        foreach (q[i]) s += q[i];
        q.push_front(`SSSP_STX);
        q.push_back(hx(s[7:4]));
        q.push_back(hx(s[3:0]));
        foreach (q[i]) begin
            i_sssp_master_model.recv_byte(b, ok);
            check({23'h0, ok, b}, {24'h1, q[i]});
        end
    endtask

    // one answer for each request, handed over a while after the strobe
    task automatic give_rsp;
        rsp_i.valid = 1'b1;
        rsp_i.data_len = 5'd4;
        rsp_i.data = {32'h31323334, 96'h0};
        @(negedge clk_i);
        rsp_i.valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_good;
        int v;
        cfg_i = '{use_p2p: 1'b0, station: 5'd0, group: 8'h61};
        v = vcnt;
        i_sssp_master_model.send_byte(`SSSP_SOH, 1'b0);
        i_sssp_master_model.send_byte(8'h30, 1'b0);
        i_sssp_master_model.send_byte(`SSSP_EOT, 1'b0);
        send_msg(8'h30, 1'b0);
        check(vcnt - v, 1);
        check({24'h0, cmd_o.station}, 32'h30);
        check({16'h0, cmd_o.command}, 32'h3031);
        check({16'h0, cmd_o.data_no}, 32'h3032);
        check({27'h0, cmd_o.data_len}, 32'h0);
        give_rsp();
        expect_reply(8'h30, `SSSP_ST_GOOD, 1'b1);
    endtask

    task automatic t_other;
        int v, e;
        v = vcnt;
        e = edge_cnt;
        send_msg(8'h35, 1'b0);
        repeat (3 * 11 * `SSSP_BIT_CYC) @(negedge clk_i);
        check(vcnt - v, 0);
        check(edge_cnt - e, 0);
        v = vcnt;
        send_msg(8'h61, 1'b0);
        check(vcnt - v, 1);
        rsp_i.cmd_bad = 1'b1;
        give_rsp();
        expect_reply(8'h30, `SSSP_ST_CMD, 1'b1);
        rsp_i.cmd_bad = 1'b0;
    endtask

    task automatic t_bcast;
        int v, e;
        cfg_i.station = 5'd3;
        v = vcnt;
        send_msg(8'h2a, 1'b0);
        check(vcnt - v, 1);
        check({31'h0, cmd_o.broadcast}, 32'h1);
        e = edge_cnt;
        give_rsp();
        repeat (3 * 11 * `SSSP_BIT_CYC) @(negedge clk_i);
        check(edge_cnt - e, 0);
    endtask

    task automatic t_bad;
        int v;
        cfg_i = '{use_p2p: 1'b1, station: 5'd0, group: 8'h61};
        alarm_i = 1'b1;
        v = vcnt;
        send_msg(8'h30, 1'b1);
        expect_reply(8'h30, `SSSP_ST_CSUM | `SSSP_ALARM_BIT, 1'b0);
        check(vcnt - v, 0);
        alarm_i = 1'b0;
    endtask

    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        alarm_i = 1'b0;
        rsp_i = '0;
        cfg_i = '{use_p2p: 1'b0, station: 5'd0, group: 8'h61};
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        // settle, then a harmless read first
        @(negedge clk_i);
        t_good();
        t_other();
        t_bcast();
        t_bad();
        summarize();
    end

    // the scenarios need about 1.9 ms of serial traffic
    initial begin
        #4_000_000;
        error_cnt++;
        summarize();
    end
endmodule // tb_top
`default_nettype wire
